// [core/dtp_pkg.sv]
package dtp_pkg;

  // ****************************************************************
  // Register map: index constants, byte address is four times index
  // ****************************************************************
  localparam int unsigned ADDR_W      = 12;
  localparam logic [7:0]  IDX_CNT1    = 8'h68;
  localparam logic [7:0]  IDX_CNT2    = 8'h69;
  localparam logic [7:0]  IDX_RLD1    = 8'h6a;
  localparam logic [7:0]  IDX_RLD2    = 8'h6b;
  localparam logic [7:0]  IDX_CTL1    = 8'h6c;
  localparam logic [7:0]  IDX_CTL2    = 8'h6d;
  localparam logic [7:0]  IDX_PDIR    = 8'h6e;
  localparam logic [7:0]  IDX_PALT    = 8'h6f;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam logic [7:0]  CTL1_RESET  = 8'h70;
  localparam logic [7:0]  CTL2_RESET  = 8'h40;
  localparam logic [7:0]  PORT_RESET  = 8'h00;
  localparam logic [7:0]  CNT_RESET   = 8'h00;
  localparam logic [7:0]  CNT_ALL_ONE = 8'hff;
  localparam logic [7:0]  CNT_ONE     = 8'h01;
  localparam int unsigned PIN_EVT1    = 4;
  localparam int unsigned PIN_OUT1    = 5;
  localparam int unsigned PIN_EVT2    = 6;
  localparam int unsigned PIN_OUT2    = 7;

  // ****************************************************************
  // Count source selection
  // ****************************************************************
  localparam logic [2:0]  SEL_EVT_RISE = 3'h6;
  localparam logic [2:0]  SEL_EVT_FALL = 3'h7;
  localparam int unsigned BASE_DIV     = 1;
  localparam logic [7:0]  BASE_DIV_MAX = 8'(BASE_DIV - 1);

  // ****************************************************************
  // Control register layouts
  // ****************************************************************
  typedef struct packed {
    logic       out;
    logic       run;
    logic [2:0] sel;
  } dtp_ctl1_t;

  typedef struct packed {
    logic       out;
    logic       pwm;
    logic       wide;
    logic       run;
    logic [2:0] sel;
  } dtp_ctl2_t;

  typedef struct packed {
    logic first;
    logic second;
  } dtp_pair_t;

endpackage

// [core/dtp_timer.sv]
`timescale 1ns/1ns
`default_nettype none

module dtp_timer
  import dtp_pkg::*;
(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              sys_reset_pulse,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Event pins
  input  wire logic              first_event_pin,
  input  wire logic              second_event_pin,
  // Timer output pins and pull-ups
  output logic                   first_pin_out,
  output logic                   first_pin_oe_n,
  output logic                   second_pin_out,
  output logic                   second_pin_oe_n,
  output logic                   first_pullup_en,
  output logic                   second_pullup_en,
  // Overflow requests
  output logic                   irq_first,
  output logic                   irq_second
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  dtp_ctl1_t  first_timer_control_reg;
  dtp_ctl2_t  second_timer_control_reg;
  logic [7:0] first_counter_reg;
  logic [7:0] second_counter_reg;
  logic [7:0] first_reload_value_reg;
  logic [7:0] second_reload_value_reg;
  logic [7:0] port_direction_reg;
  logic [7:0] port_alt_function_reg;
  logic       pwm_ff_reg;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  logic       acc_first;
  logic       wr_en;
  logic [ADDR_W-3:0] idx;
  logic       hit;
  logic [7:0] rd_byte;
  logic [7:0] wbyte;

  assign idx       = paddr[ADDR_W-1:2];
  assign acc_first = psel && penable && !pready;
  assign wr_en     = psel && penable && pready && pwrite && !pslverr;
  assign wbyte     = pwdata[7:0];

  always_comb
  begin
    hit     = 1'b1;
    rd_byte = 8'h00;
    case (idx)
      IDX_CNT1: rd_byte = first_counter_reg;
      IDX_CNT2: rd_byte = second_counter_reg;
      IDX_RLD1: rd_byte = first_reload_value_reg;
      IDX_RLD2: rd_byte = second_reload_value_reg;
      IDX_CTL1: rd_byte = {first_timer_control_reg.out, 3'h7,
                           first_timer_control_reg.run,
                           first_timer_control_reg.sel};
      IDX_CTL2: rd_byte = {second_timer_control_reg.out, 1'b1,
                           second_timer_control_reg[5:0]};
      IDX_PDIR: rd_byte = port_direction_reg;
      IDX_PALT: rd_byte = port_alt_function_reg;
      default:  hit     = 1'b0;
    endcase
    if (paddr[1:0] != 2'h0)
    begin
      hit = 1'b0;
    end
  end

  // One wait state: the answer is registered in the first access cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end
    else
    begin
      pready  <= acc_first;
      pslverr <= acc_first && !hit;
      if (acc_first)
      begin
        prdata <= (hit && !pwrite) ? {24'h0, rd_byte} : 32'h0;
      end
    end
  end

  // ****************************************************************
  // Base enable divider and shared prescaler
  // ****************************************************************
  logic [7:0] base_div_reg;
  logic       base_en;
  logic [7:0] presc_reg;

  assign base_en = (base_div_reg == BASE_DIV_MAX);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      base_div_reg <= 8'h00;
      presc_reg    <= 8'h00;
    end
    else
    begin
      base_div_reg <= base_en ? 8'h00 : base_div_reg + CNT_ONE;
      if (base_en)
      begin
        presc_reg <= presc_reg + CNT_ONE;
      end
    end
  end

  // ****************************************************************
  // Event pin synchronisers and edge detection
  // ****************************************************************
  dtp_pair_t evt_s1_reg;
  dtp_pair_t evt_s2_reg;
  dtp_pair_t evt_old_reg;
  dtp_pair_t rise;
  dtp_pair_t fall;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      evt_s1_reg  <= '0;
      evt_s2_reg  <= '0;
      evt_old_reg <= '0;
    end
    else
    begin
      evt_s1_reg  <= {first_event_pin, second_event_pin};
      evt_s2_reg  <= evt_s1_reg;
      evt_old_reg <= evt_s2_reg;
    end
  end

  assign rise = evt_s2_reg & ~evt_old_reg;
  assign fall = ~evt_s2_reg & evt_old_reg;

  function automatic logic src_tick(input logic [2:0] sel,
                                    input logic       ev_rise,
                                    input logic       ev_fall,
                                    input logic       ben,
                                    input logic [7:0] pre);
    logic [7:0] mask;
    mask = 8'h00;
    case (sel)
      3'h1:    mask = 8'h01;
      3'h2:    mask = 8'h03;
      3'h3:    mask = 8'h07;
      3'h4:    mask = 8'h1f;
      3'h5:    mask = 8'hff;
      default: mask = 8'h00;
    endcase
    if (sel == SEL_EVT_RISE)
    begin
      return ev_rise;
    end
    if (sel == SEL_EVT_FALL)
    begin
      return ev_fall;
    end
    return ben && ((pre & mask) == mask);
  endfunction

  // ****************************************************************
  // Count steps and overflows
  // ****************************************************************
  logic tick1;
  logic tick2;
  logic ovf1;
  logic ovf2;
  logic mode_wide;
  logic mode_pwm;

  assign mode_wide = second_timer_control_reg.wide;
  assign mode_pwm  = second_timer_control_reg.pwm && !mode_wide;

  assign tick1 = first_timer_control_reg.run &&
                 src_tick(first_timer_control_reg.sel, rise.first,
                          fall.first, base_en, presc_reg);
  assign ovf1  = tick1 && (first_counter_reg == CNT_ALL_ONE);

  always_comb
  begin
    if (mode_wide)
    begin
      tick2 = ovf1;
    end
    else if (mode_pwm)
    begin
      tick2 = first_timer_control_reg.run &&
              src_tick(second_timer_control_reg.sel, rise.second,
                       fall.second, base_en, presc_reg);
    end
    else
    begin
      tick2 = second_timer_control_reg.run &&
              src_tick(second_timer_control_reg.sel, rise.second,
                       fall.second, base_en, presc_reg);
    end
  end

  assign ovf2 = tick2 && (second_counter_reg == CNT_ALL_ONE);

  // ****************************************************************
  // Counters and reload values
  // ****************************************************************
  logic chain_reload;

  assign chain_reload = ovf2 && (mode_wide || mode_pwm);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      first_counter_reg      <= CNT_RESET;
      first_reload_value_reg <= CNT_RESET;
    end
    else if (wr_en && idx == IDX_CNT1)
    begin
      first_counter_reg      <= wbyte;
      first_reload_value_reg <= wbyte;
    end
    else
    begin
      if (wr_en && idx == IDX_RLD1)
      begin
        first_reload_value_reg <= wbyte;
      end
      if (chain_reload || (ovf1 && !mode_wide && !mode_pwm))
      begin
        first_counter_reg <= first_reload_value_reg;
      end
      else if (tick1)
      begin
        first_counter_reg <= first_counter_reg + CNT_ONE;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      second_counter_reg      <= CNT_RESET;
      second_reload_value_reg <= CNT_RESET;
    end
    else if (wr_en && idx == IDX_CNT2)
    begin
      second_counter_reg      <= wbyte;
      second_reload_value_reg <= wbyte;
    end
    else
    begin
      if (wr_en && idx == IDX_RLD2)
      begin
        second_reload_value_reg <= wbyte;
      end
      if (ovf2)
      begin
        second_counter_reg <= second_reload_value_reg;
      end
      else if (tick2)
      begin
        second_counter_reg <= second_counter_reg + CNT_ONE;
      end
    end
  end

  // ****************************************************************
  // Control registers and port setup
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      first_timer_control_reg <= dtp_ctl1_t'({CTL1_RESET[7], CTL1_RESET[3:0]});
    end
    else if (sys_reset_pulse)
    begin
      first_timer_control_reg <= dtp_ctl1_t'({CTL1_RESET[7], CTL1_RESET[3:0]});
    end
    else if (wr_en && idx == IDX_CTL1)
    begin
      first_timer_control_reg <= dtp_ctl1_t'({wbyte[7], wbyte[3:0]});
    end
    else if (ovf1)
    begin
      first_timer_control_reg.out <= !first_timer_control_reg.out;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      second_timer_control_reg <= dtp_ctl2_t'({CTL2_RESET[7], CTL2_RESET[5:0]});
    end
    else if (sys_reset_pulse)
    begin
      second_timer_control_reg <= dtp_ctl2_t'({CTL2_RESET[7], CTL2_RESET[5:0]});
    end
    else if (wr_en && idx == IDX_CTL2)
    begin
      second_timer_control_reg <= dtp_ctl2_t'({wbyte[7], wbyte[5:0]});
    end
    else if (ovf2)
    begin
      second_timer_control_reg.out <= !second_timer_control_reg.out;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_direction_reg    <= PORT_RESET;
      port_alt_function_reg <= PORT_RESET;
    end
    else if (sys_reset_pulse)
    begin
      port_direction_reg    <= PORT_RESET;
      port_alt_function_reg <= PORT_RESET;
    end
    else
    begin
      if (wr_en && idx == IDX_PDIR)
      begin
        port_direction_reg <= wbyte;
      end
      if (wr_en && idx == IDX_PALT)
      begin
        port_alt_function_reg <= wbyte;
      end
    end
  end

  // ****************************************************************
  // Pulse flip-flop, pins and overflow requests
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pwm_ff_reg <= 1'b0;
    end
    else if (ovf2)
    begin
      pwm_ff_reg <= 1'b0;
    end
    else if (ovf1)
    begin
      pwm_ff_reg <= 1'b1;
    end
  end

  // Pins show the level one cycle after the register changes.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      first_pin_out    <= 1'b0;
      second_pin_out   <= 1'b0;
      first_pin_oe_n   <= 1'b1;
      second_pin_oe_n  <= 1'b1;
      first_pullup_en  <= 1'b0;
      second_pullup_en <= 1'b0;
      irq_first        <= 1'b0;
      irq_second       <= 1'b0;
    end
    else
    begin
      first_pin_out    <= mode_pwm ? pwm_ff_reg : first_timer_control_reg.out;
      second_pin_out   <= mode_pwm ? !pwm_ff_reg : second_timer_control_reg.out;
      first_pin_oe_n   <= !(port_direction_reg[PIN_OUT1] && port_alt_function_reg[PIN_OUT1]);
      second_pin_oe_n  <= !(port_direction_reg[PIN_OUT2] && port_alt_function_reg[PIN_OUT2]);
      first_pullup_en  <= !port_direction_reg[PIN_EVT1] && port_alt_function_reg[PIN_EVT1];
      second_pullup_en <= !port_direction_reg[PIN_EVT2] && port_alt_function_reg[PIN_EVT2];
      irq_first        <= ovf1;
      irq_second       <= ovf2;
    end
  end

endmodule

`default_nettype wire

// [tb/dtp_chk.sv]
`timescale 1ns/1ns
`default_nettype none

module dtp_chk
  import dtp_pkg::*;
(
  // Clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              sys_reset_pulse,
  // Register bus
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Pin controls
  input wire logic              first_pin_oe_n,
  input wire logic              second_pin_oe_n,
  input wire logic              first_pullup_en,
  input wire logic              second_pullup_en
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [7:0] dir_s;
  logic [7:0] alt_s;
  logic       bad;
  logic       wr;

  // *******************************************
  // Shadow copies of the two port registers
  // *******************************************
  assign bad = paddr[11:5] != 7'h0d || paddr[1:0] != 2'h0;
  assign wr  = pready && pwrite && !pslverr;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      dir_s <= 8'h00;
    else if (sys_reset_pulse)
      dir_s <= 8'h00;
    else if (wr && paddr == {2'h0, IDX_PDIR, 2'h0})
      dir_s <= pwdata[7:0];

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      alt_s <= 8'h00;
    else if (sys_reset_pulse)
      alt_s <= 8'h00;
    else if (wr && paddr == {2'h0, IDX_PALT, 2'h0})
      alt_s <= pwdata[7:0];

  // *******************************************
  // Bus and pin properties
  // *******************************************
  sequence acc_s;
    psel && !penable ##1 psel && penable;
  endsequence

  ans_time_a: assert property (acc_s |=> pready) else $error("answer late");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
  bad_addr_a: assert property (acc_s ##0 bad |=> pslverr) else $error("no error");
  good_addr_a: assert property (acc_s ##0 !bad |=> !pslverr) else $error("false error");
  zero_data_a: assert property (pready && (pslverr || pwrite) |-> prdata == 32'h0)
    else $error("data not zero");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper bits");
  bit_six_a: assert property (
    pready && !pwrite && paddr == {2'h0, IDX_CTL2, 2'h0} |-> prdata[6]) else $error("bit six");
  out_one_a: assert property (
    first_pin_oe_n == !$past(dir_s[PIN_OUT1] && alt_s[PIN_OUT1])) else $error("oe one");
  out_two_a: assert property (
    second_pin_oe_n == !$past(dir_s[PIN_OUT2] && alt_s[PIN_OUT2])) else $error("oe two");
  pull_one_a: assert property (
    first_pullup_en == $past(!dir_s[PIN_EVT1] && alt_s[PIN_EVT1])) else $error("pull one");
  pull_two_a: assert property (
    second_pullup_en == $past(!dir_s[PIN_EVT2] && alt_s[PIN_EVT2])) else $error("pull two");
endmodule

`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ns
`default_nettype none

module tb
  import dtp_pkg::*;
;
  logic              pclk, presetn, sys_reset_pulse, psel, penable, pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rs;
  logic              pready, pslverr, first_event_pin, second_event_pin;
  logic              first_pin_out, first_pin_oe_n, second_pin_out, second_pin_oe_n;
  logic              first_pullup_en, second_pullup_en, irq_first, irq_second;
  logic [8:0]        q[$];
  logic [7:0]        v;
  logic [2:0]        s;
  int                bad_count, n_compared, t, i;
  int                irq_n[2];

  dtp_timer dut (.pclk, .presetn, .sys_reset_pulse, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .first_event_pin, .second_event_pin,
    .first_pin_out, .first_pin_oe_n, .second_pin_out, .second_pin_oe_n,
    .first_pullup_en, .second_pullup_en, .irq_first, .irq_second);

  // *******************************************
  // Helpers
  // *******************************************
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    if (bad_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic apb(input logic w, input int ix, input logic [7:0] d, input logic [8:0] e);
    q.push_back(e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'h0, 8'(ix), 2'h0};
    pwdata  <= {24'(rnd()), d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input int ix, input logic [7:0] d);
    apb(1'b1, ix, d, 9'h000);
  endtask

  task automatic rd(input int ix, input logic [7:0] e);
    apb(1'b0, ix, 8'h00, {1'b0, e});
  endtask

  task automatic ev(input logic [1:0] m, input int n);
    repeat (n)
    begin
      first_event_pin  <= m[0];
      second_event_pin <= m[1];
      repeat (6) @(posedge pclk);
      first_event_pin  <= 1'b0;
      second_event_pin <= 1'b0;
      repeat (6) @(posedge pclk);
    end
  endtask

  // *******************************************
  // Clock, watchdog and result monitor
  // *******************************************
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  initial
  begin
    #400000;
    bad_count++;
    end_of_test();
  end

  always @(posedge pclk)
  begin
    if (irq_first === 1'b1)
      irq_n[0]++;
    if (irq_second === 1'b1)
      irq_n[1]++;
    if (pready === 1'b1)
      cmp({pslverr, prdata[7:0]}, q.size() ? q.pop_front() : 9'h1ff);
  end

  // *******************************************
  // Main sequence
  // *******************************************
  initial
  begin
    {presetn, sys_reset_pulse, psel, penable, pwrite} = '0;
    {first_event_pin, second_event_pin} = '0;
    paddr = '0;
    pwdata = '0;
    rs = 32'd32047;
    irq_n = '{0, 0};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(IDX_CTL1, 8'h70);
    rd(IDX_CTL2, 8'h40);
    repeat (4)
    begin
      v = 8'(rnd()) & 8'hc7;
      wr(IDX_CTL2, v);
      rd(IDX_CTL2, v | 8'h40);
    end
    apb(1'b1, 8'h70, 8'h55, 9'h100);
    apb(1'b0, 8'h67, 8'h00, 9'h100);
    for (i = 0; i < 2; i++)
    begin
      v = 8'(rnd());
      wr(IDX_CNT1 + i, v);
      rd(IDX_CNT1 + i, v);
      rd(IDX_RLD1 + i, v);
    end
    wr(IDX_CNT1, 8'h00);
    wr(IDX_CTL1, 8'h08);
    wr(IDX_CTL1, 8'h00);
    rd(IDX_CNT1, 8'h04);
    for (i = 0; i < 4; i++)
    begin
      t = i % 2;
      s = (i < 2) ? 3'h6 : 3'h7;
      wr(IDX_CNT1 + t, 8'hfe);
      wr(IDX_RLD1 + t, 8'h10);
      irq_n = '{0, 0};
      wr(IDX_CTL1 + t, {5'h01, s});
      ev(t ? 2'b10 : 2'b01, 3);
      rd(IDX_CNT1 + t, 8'h11);
      rd(IDX_CTL1 + t, (t ? 8'hc8 : 8'hf8) | {5'h00, s});
      cmp({8'h00, t ? second_pin_out : first_pin_out}, 9'h001);
      cmp(9'(irq_n[t]), 9'h001);
      wr(IDX_CTL1 + t, 8'h00);
    end
    wr(IDX_CNT1, 8'hff);
    wr(IDX_CNT2, 8'hfe);
    wr(IDX_RLD1, 8'h20);
    wr(IDX_RLD2, 8'h30);
    wr(IDX_CTL2, 8'h18);
    irq_n = '{0, 0};
    wr(IDX_CTL1, 8'h0e);
    ev(2'b01, 2);
    rd(IDX_CNT1, 8'h01);
    rd(IDX_CNT2, 8'hff);
    ev(2'b01, 255);
    rd(IDX_CNT1, 8'h20);
    rd(IDX_CNT2, 8'h30);
    rd(IDX_CTL2, 8'hd8);
    rd(IDX_CTL1, 8'h7e);
    cmp(9'(irq_n[0]), 9'h002);
    cmp(9'(irq_n[1]), 9'h001);
    wr(IDX_CTL1, 8'h00);
    wr(IDX_CNT1, 8'hff);
    wr(IDX_CNT2, 8'hfe);
    wr(IDX_CTL2, 8'h26);
    irq_n = '{0, 0};
    wr(IDX_CTL1, 8'h0e);
    ev(2'b11, 1);
    cmp({7'h00, first_pin_out, second_pin_out}, 9'h002);
    wr(IDX_CNT1, 8'hff);
    ev(2'b11, 1);
    cmp({7'h00, first_pin_out, second_pin_out}, 9'h001);
    cmp(9'(irq_n[0]), 9'h002);
    cmp(9'(irq_n[1]), 9'h001);
    wr(IDX_PDIR, 8'ha0);
    wr(IDX_PALT, 8'hf0);
    ev(2'b00, 1);
    cmp({7'h00, first_pin_oe_n, second_pin_oe_n}, 9'h000);
    cmp({7'h00, first_pullup_en, second_pullup_en}, 9'h003);
    sys_reset_pulse <= 1'b1;
    @(posedge pclk);
    sys_reset_pulse <= 1'b0;
    ev(2'b00, 1);
    cmp({7'h00, first_pin_oe_n, second_pin_oe_n}, 9'h003);
    rd(IDX_CTL2, 8'h40);
    rd(IDX_CTL1, 8'h70);
    rd(IDX_CNT2, 8'hfe);
    cmp(9'(q.size()), 9'h000);
    end_of_test();
  end
endmodule

bind dtp_timer dtp_chk chk (.pclk, .presetn, .sys_reset_pulse, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .first_pin_oe_n, .second_pin_oe_n,
  .first_pullup_en, .second_pullup_en);

`default_nettype wire
